// ### fcp_consts.vh
// Constants of the flash command-parameter block.
// Included by the design files; definitions only.
`ifndef FCP_CONSTS_VH
`define FCP_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FCP_OFF_STATUS 12'h000
`define FCP_OFF_INDEX 12'h004
`define FCP_OFF_PARAM 12'h008
`define FCP_OFF_RSV 12'h00c
`define FCP_OFF_IRQ_STAT 12'h010
`define FCP_OFF_IRQ_MASK 12'h014
// ----------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------
`define FCP_ST_CCF 7
`define FCP_ST_ACCERR 5
`define FCP_ST_VIOL 4
`define FCP_ST_VERR 0
`define FCP_IRQ_DONE 0
`define FCP_IRQ_ERR 1
`define FCP_IDX_RST 3'h0
`define FCP_PARAM_RST 16'h0000
// ----------------------------------------------------------------
// Parameter array indices and command fields
// ----------------------------------------------------------------
`define FCP_IDX_CMD 3'h0
`define FCP_IDX_ADDR 3'h1
`define FCP_IDX_LAST 3'h5
`define FCP_CMD_HI 15
`define FCP_CMD_LO 8
`define FCP_CMD_ONCE 8'h07
`define FCP_ONCE_MAX 16'h0007
`define FCP_INVALID_RD 16'hffff
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FCP_PROG_NS 40000
`define FCP_CLK_NS 40
`endif

// ### fcp_ctrl.v
// Flash command-parameter array and one-time-program sequencer.
// Assumes a single AHB-Lite master; hready is this slave's hreadyout.
// Notes on behaviour
// RULE_01 - Program once checks the phrase is blank, programs, reads back.
// RULE_02 - The complete flag stays low until program and verify finish.
// RULE_03 - A phrase already programmed is never programmed again.
// RULE_04 - Software gives a phrase index from 0 to 7.
// RULE_05 - Reads of flash block 0 return invalid data during the command.
// RULE_06 - Results in the array are valid once the complete flag is one.
// RULE_07 - Writes at indices 6 and 7 are dropped and those read zero.
// RULE_08 - Index 0 high byte holds the command code.
// RULE_09 - Global address spans index 0 low byte and index 1.
// RULE_10 - Data words 0 to 3 sit at indices 2 to 5.
// RULE_11 - The factory test register reads zero and ignores writes.
// RULE_12 - Software programs a phrase once and not from block 0 code.
// RULE_13 - A failed blank check skips programming, flags an error, ends.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "fcp_consts.vh"
module fcp_ctrl #(
  parameter PROG_CYC = (`FCP_PROG_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS
) (
  input wire hclk, // Bus clock
  input wire hresetn, // Async reset, active low
  input wire hsel, // Slave select
  input wire [11:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size
  input wire hready, // Bus ready
  input wire [31:0] hwdata, // Write data
  output wire [31:0] hrdata, // Read data
  output wire hreadyout, // Slave ready
  output wire hresp, // Always OKAY
  input wire blk0_rd, // Read request into flash block 0
  input wire [15:0] blk0_rdata_in, // Array data of block 0
  output reg [15:0] blk0_rdata, // Data returned to the reader
  output wire busy, // Command in progress
  output wire irq // Level interrupt
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_BLANK = 3'd1;
  localparam S_CHECK = 3'd2;
  localparam S_PROG = 3'd3;
  localparam S_VREAD = 3'd4;
  localparam S_VERIFY = 3'd5;
  localparam S_DONE = 3'd6;

  reg [2:0] state_q;
  reg [15:0] param_q [0:5];
  reg [2:0] idx_q;
  reg ccf_q;
  reg accerr_q;
  reg viol_q;
  reg verr_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg [31:0] cnt_q;
  reg wr_ph_q;
  reg rd_ph_q;
  reg [11:0] ph_addr_q;
  reg [31:0] rdata_q;
  reg ev_done;
  reg ev_err;
  wire [63:0] mem_rdata;
  wire [63:0] phrase;
  wire mem_wen;
  wire launch;
  wire acc;
  integer k;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign acc = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign busy = ~ccf_q;

  // Capture address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      ph_addr_q <= 12'h000;
    end else begin
      wr_ph_q <= acc & hwrite;
      rd_ph_q <= acc & ~hwrite;
      ph_addr_q <= haddr;
    end
  end

  // Writing one to the complete flag while idle launches a command
  assign launch = wr_ph_q & (ph_addr_q == `FCP_OFF_STATUS) &
                  hwdata[`FCP_ST_CCF] & ccf_q;

  // Phrase built from data words 0 to 3, word 0 highest [RULE_10]
  assign phrase = {param_q[2], param_q[3], param_q[4], param_q[5]};

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (acc & ~hwrite) begin
      case (haddr)
        `FCP_OFF_STATUS: rdata_q <= {24'h000000, ccf_q, 1'b0, accerr_q,
                                     viol_q, 3'h0, verr_q};
        `FCP_OFF_INDEX: rdata_q <= {29'h00000000, idx_q};
        // Unimplemented indices read zero [RULE_07]
        `FCP_OFF_PARAM: rdata_q <= (idx_q > `FCP_IDX_LAST) ? 32'h00000000 :
                                   {16'h0000, param_q[idx_q]}; // [RULE_06]
        `FCP_OFF_RSV: rdata_q <= 32'h00000000; // [RULE_11]
        `FCP_OFF_IRQ_STAT: rdata_q <= {30'h00000000, irq_stat_q};
        `FCP_OFF_IRQ_MASK: rdata_q <= {30'h00000000, irq_mask_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Parameter array and index
  // ----------------------------------------------------------------
  // Cmd code at index 0 high byte, address in 0 low and 1 [RULE_08]
  // Bit 7 of index 0 low byte is forced zero [RULE_09]
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_q <= `FCP_IDX_RST;
      for (k = 0; k < 6; k = k + 1) begin
        param_q[k] <= `FCP_PARAM_RST;
      end
    end else if (wr_ph_q & ccf_q) begin
      if (ph_addr_q == `FCP_OFF_INDEX) begin
        idx_q <= hwdata[2:0];
      end
      // Writes at indices 6 and 7 dropped [RULE_07]
      if ((ph_addr_q == `FCP_OFF_PARAM) && (idx_q <= `FCP_IDX_LAST)) begin
        if (idx_q == `FCP_IDX_CMD) begin
          param_q[idx_q] <= {hwdata[15:8], 1'b0, hwdata[6:0]}; // [RULE_09]
        end else begin
          param_q[idx_q] <= hwdata[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // One-time-program sequencer
  // ----------------------------------------------------------------
  assign mem_wen = (state_q == S_PROG) && (cnt_q == 32'd0);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_IDLE;
      ccf_q <= 1'b1;
      accerr_q <= 1'b0;
      viol_q <= 1'b0;
      verr_q <= 1'b0;
      cnt_q <= 32'd0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (wr_ph_q && (ph_addr_q == `FCP_OFF_STATUS) && ccf_q) begin
            // Writing one clears stale ACCERR and VIOL flags
            if (hwdata[`FCP_ST_ACCERR]) begin
              accerr_q <= 1'b0;
            end
            if (hwdata[`FCP_ST_VIOL]) begin
              viol_q <= 1'b0;
            end
          end
          if (launch) begin
            ccf_q <= 1'b0; // [RULE_02]
            verr_q <= 1'b0;
            // Bad code, index out of range or not at last index
            if ((param_q[0][`FCP_CMD_HI:`FCP_CMD_LO] != `FCP_CMD_ONCE) ||
                (param_q[1] > `FCP_ONCE_MAX) ||
                (idx_q != `FCP_IDX_LAST)) begin
              accerr_q <= 1'b1;
              state_q <= S_DONE;
            end else begin
              state_q <= S_BLANK; // [RULE_01]
            end
          end
        end
        S_BLANK: begin
          state_q <= S_CHECK;
        end
        S_CHECK: begin
          // Already programmed: refuse and finish [RULE_03] [RULE_13]
          if (mem_rdata != {64{1'b1}}) begin
            viol_q <= 1'b1;
            state_q <= S_DONE;
          end else begin
            cnt_q <= PROG_CYC - 1;
            state_q <= S_PROG;
          end
        end
        S_PROG: begin
          if (cnt_q == 32'd0) begin
            state_q <= S_VREAD; // [RULE_01]
          end else begin
            cnt_q <= cnt_q - 32'd1;
          end
        end
        S_VREAD: begin
          state_q <= S_VERIFY;
        end
        S_VERIFY: begin
          if (mem_rdata != phrase) begin
            verr_q <= 1'b1;
          end
          state_q <= S_DONE;
        end
        S_DONE: begin
          ccf_q <= 1'b1; // [RULE_02]
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Phrase store; launch rejects an index above 7 with ACCERR [RULE_04]
  fcp_once_mem #(
    .AW(3),
    .DW(64)
  ) u_mem (
    .hclk(hclk),
    .addr(param_q[1][2:0]),
    .wen(mem_wen),
    .wdata(phrase),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // Block 0 read path
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk0_rdata <= 16'h0000;
    end else if (blk0_rd) begin
      blk0_rdata <= ccf_q ? blk0_rdata_in : `FCP_INVALID_RD; // [RULE_05]
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always @* begin
    ev_done = (state_q == S_DONE);
    ev_err = (state_q == S_DONE) & (accerr_q | viol_q | verr_q);
  end

  // Sticky bits, write one to clear, set wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end else begin
      if (wr_ph_q && (ph_addr_q == `FCP_OFF_IRQ_MASK)) begin
        irq_mask_q <= hwdata[1:0];
      end
      irq_stat_q <= (irq_stat_q &
                    ~((wr_ph_q && (ph_addr_q == `FCP_OFF_IRQ_STAT)) ?
                      hwdata[1:0] : 2'h0)) |
                    {ev_err, ev_done};
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);
endmodule

// ### fcp_ctrl_assertions.sv
// Port checker for the flash command-parameter block.
// Bound to fcp_ctrl; one clock, active-low async reset.
`timescale 1ns/1ps
module fcp_ctrl_assertions #(
  parameter PROG_CYC = 4
) (
  input wire hclk, // Clock
  input wire hresetn, // Reset, low
  input wire hsel, // Select
  input wire [11:0] haddr, // Address
  input wire [1:0] htrans, // Type
  input wire hwrite, // Write
  input wire hready, // Bus ready
  input wire [31:0] hrdata, // Read data
  input wire hreadyout, // Ready out
  input wire hresp, // Response
  input wire blk0_rd, // Block 0 read
  input wire [15:0] blk0_rdata_in, // Array data
  input wire [15:0] blk0_rdata, // Returned data
  input wire busy // Running
);
  // ------------------------------------------------
  // Read address phase and timing bounds
  // ------------------------------------------------
  localparam int MAXB = PROG_CYC + 20;
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("slave stalled or errored");
  a_rsv_zero: assert property (
    rd_take && haddr == 12'h00c |=> hrdata == 32'h0)
    else $error("reserved register not zero");
  a_ccf_read: assert property (
    rd_take && haddr == 12'h000 |=> hrdata[7] == !$past(busy))
    else $error("complete bit disagrees with busy");
  a_blk0_bad: assert property (
    blk0_rd && busy |=> blk0_rdata == 16'hffff)
    else $error("block 0 data valid during command");
  a_blk0_pass: assert property (
    blk0_rd && !busy |=> blk0_rdata == $past(blk0_rdata_in))
    else $error("block 0 data not passed");
  a_busy_ends: assert property (
    $rose(busy) |-> ##[1:MAXB] !busy)
    else $error("command never completes");
  a_busy_min: assert property ($rose(busy) ##1 busy |-> busy[*2])
    else $error("command too short");
  a_upper_zero: assert property (
    rd_take |=> hrdata[31:16] == 16'h0)
    else $error("upper read bits set");
endmodule
bind fcp_ctrl fcp_ctrl_assertions #(.PROG_CYC(PROG_CYC))
  fcp_ctrl_assertions_inst (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .blk0_rd(blk0_rd), .blk0_rdata_in(blk0_rdata_in),
  .blk0_rdata(blk0_rdata), .busy(busy));

// ### fcp_ctrl_test.sv
// Testbench: AHB-Lite master and checks for fcp_ctrl.
// Assumes the flash model and the checker are compiled first.
`timescale 1ns/1ps
`include "fcp_consts.vh"
module fcp_ctrl_test;
  localparam PC = 4;
  localparam [11:0] ST = `FCP_OFF_STATUS, IX = `FCP_OFF_INDEX;
  localparam [11:0] PA = `FCP_OFF_PARAM, RS = `FCP_OFF_RSV;
  localparam [11:0] IS = `FCP_OFF_IRQ_STAT, MK = `FCP_OFF_IRQ_MASK;
  reg hclk = 0, hresetn = 0, hwrite = 0, blk0_rd = 0;
  reg [11:0] haddr = 0;
  reg [1:0] htrans = 0;
  reg [31:0] hwdata = 0, q;
  wire [31:0] hrdata;
  wire hreadyout, hresp, busy, irq;
  wire [15:0] blk0_rdata_in, blk0_rdata;
  int n_errors = 0, comparisons = 0, n, i;
  // ------------------------------------------------
  // Clock, design and array model
  // ------------------------------------------------
  always #20 hclk = ~hclk;
  fcp_ctrl #(.PROG_CYC(PC)) fcp_ctrl_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .blk0_rd(blk0_rd), .blk0_rdata_in(blk0_rdata_in),
    .blk0_rdata(blk0_rdata), .busy(busy), .irq(irq));
  fcp_flash_model fcp_flash_model_inst (.hclk(hclk),
    .blk0_rd(blk0_rd), .blk0_rdata_in(blk0_rdata_in));
  // Compare and count
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // One single AHB-Lite transfer, entered just after an edge
  task automatic xfer(input [11:0] a, input w, input [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input [11:0] a, input [31:0] e, input string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic irq_is(input e);
    #1 chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge hclk);
  endtask
  // Load a program-once command for one phrase
  task automatic load(input [31:0] ph);
    wr(IX, 0);
    wr(PA, {16'h0, `FCP_CMD_ONCE, 8'h00});
    wr(IX, 1);
    wr(PA, ph);
    for (i = 2; i < 6; i++) begin
      wr(IX, i);
      wr(PA, 32'hd000 + i);
    end
  endtask
  // Launch, read block 0 meanwhile, count busy cycles
  task automatic run;
    wr(ST, 32'h80);
    n = 0;
    blk0_rd <= 1;
    #1;
    while (busy !== 1'b0 && n < 400) begin
      if (n > 0) chk("blk0", 32'hffff, blk0_rdata);
      @(posedge hclk);
      #1 n++;
    end
    blk0_rd <= 0;
    @(posedge hclk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ------------------------------------------------
  // Test sequence
  // ------------------------------------------------
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    rd(ST, 32'h80, "status");
    wr(RS, 32'hff);
    rd(RS, 32'h0, "reserved");
    xfer(12'h020, 1'b0, 32'h0);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      wr(IX, i);
      wr(PA, 32'hf0f0 ^ (32'h1111 * i));
    end
    for (i = 0; i < 8; i++) begin
      wr(IX, i);
      rd(PA, i > 5 ? 0 : i ? 32'hf0f0 ^ (32'h1111 * i) : 32'hf070,
        "param");
    end
    $display("test array done");
    wr(MK, 32'h3);
    load(2);
    run;
    chk("long", 1, n >= PC);
    irq_is(1);
    rd(ST, 32'h80, "status");
    rd(IS, 32'h1, "irq_stat");
    rd(PA, 32'hd005, "result");
    blk0_rd <= 1;
    @(posedge hclk);
    #1 chk("blk0", 8'h5a, blk0_rdata[15:8]);
    blk0_rd <= 0;
    @(posedge hclk);
    wr(IS, 32'h3);
    irq_is(0);
    $display("test program done");
    run;
    chk("short", 1, n < PC);
    rd(ST, 32'h90, "status");
    irq_is(1);
    wr(ST, 32'h30);
    wr(IS, 32'h3);
    $display("test repeat done");
    wr(IX, 1);
    wr(PA, 32'h8);
    wr(IX, 5);
    run;
    rd(ST, 32'ha0, "status");
    wr(MK, 32'h0);
    irq_is(0);
    wr(MK, 32'h3);
    irq_is(1);
    wr(IS, 32'h3);
    irq_is(0);
    $display("test index done");
    give_verdict;
  end
  // Cut a hang short
  initial begin
    #(40 * 5000);
    n_errors++;
    give_verdict;
  end
endmodule

// ### fcp_flash_model.sv
// Flash array model that answers block 0 reads.
// Assumes one clock; data hold only while a read is asked.
`timescale 1ns/1ps
module fcp_flash_model (
  input wire hclk, // Clock
  input wire blk0_rd, // Read request
  output wire [15:0] blk0_rdata_in // Array data
);
  reg [7:0] cnt_q = 8'h00;
  // Moving pattern, so stale data never look valid
  always @(posedge hclk) begin
    cnt_q <= cnt_q + 8'h01;
  end
  // Stored word on read, inverted junk otherwise
  assign blk0_rdata_in = blk0_rd ? {8'h5a, cnt_q} : {8'ha5, ~cnt_q};
endmodule

// ### fcp_once_mem.v
// Small memory holding the eight one-time-programmable phrases.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ps
module fcp_once_mem #(
  parameter AW = 3,
  parameter DW = 64
) (
  input wire hclk, // Clock
  input wire [AW-1:0] addr, // Phrase index
  input wire wen, // Write strobe
  input wire [DW-1:0] wdata, // Phrase to store
  output reg [DW-1:0] rdata // Registered read data
);
  reg [DW-1:0] mem_q [0:(1<<AW)-1];
  integer i;

  // Start erased so blank checks pass
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      mem_q[i] = {DW{1'b1}};
    end
  end

  // Write port and registered read port
  always @(posedge hclk) begin
    if (wen) begin
      mem_q[addr] <= wdata;
    end
    rdata <= mem_q[addr];
  end
endmodule
